// file: bench/mpc_partition_ctrl_props.sv
// mpc_partition_ctrl_props: port checks of the partition control block.
// assumes it is bound to mpc_partition_ctrl and sees only its ports.
`timescale 1ns/1ns
module mpc_partition_ctrl_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// moves and decode
	input wire logic external_data_move,
	input wire mpc_pkg::mpc_addr_t move_addr,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two_n,
	input wire logic move_in_data,
	input wire logic move_out_of_range,
	input wire mpc_pkg::mpc_addr_t partition_addr,
	input wire mpc_pkg::mpc_addr_t range_top,
	// integrity check
	input wire logic check_rd_en,
	input wire logic program_load_mode,
	input wire logic app_start
);
	import mpc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_cs_one_low: assert property (
		external_data_move |=> chip_select_one_n != chip_select_two_n)
		else $error("move did not select one device");
	a_cs_idle: assert property (
		!external_data_move |=> chip_select_one_n && chip_select_two_n)
		else $error("select active without move");
	a_in_data: assert property (
		external_data_move |=> move_in_data == ($past(move_addr) >= partition_addr))
		else $error("data space flag wrong");
	a_out_range: assert property (
		external_data_move |=> move_out_of_range == ($past(move_addr) > range_top))
		else $error("range flag wrong");
	a_part_decode: assert property (
		partition_addr[10:0] == 11'h000 && partition_addr <= 16'h8000 && partition_addr != 16'h7800)
		else $error("partition address not a legal step");
	a_top_values: assert property (
		range_top == 16'h1fff || range_top == 16'h7fff)
		else $error("range top not legal");
	a_reset_vals: assert property (
		$rose(presetn) |-> partition_addr == 16'h8000 && range_top == 16'h7fff)
		else $error("decode not at reset values");
	a_rd_pulse: assert property (
		check_rd_en |=> !check_rd_en)
		else $error("check read held two cycles");
	a_load_excl: assert property (
		!(program_load_mode && app_start))
		else $error("load mode and start together");
	c_out_range: cover property (external_data_move ##1 move_out_of_range);
	c_sel_two: cover property (external_data_move ##1 !chip_select_two_n);
	c_load: cover property ($rose(program_load_mode));
endmodule : mpc_partition_ctrl_props

bind mpc_partition_ctrl mpc_partition_ctrl_props u_props (.pclk, .presetn, .external_data_move,
	.move_addr, .chip_select_one_n, .chip_select_two_n, .move_in_data, .move_out_of_range,
	.partition_addr, .range_top, .check_rd_en, .program_load_mode, .app_start);

// file: bench/mpc_partition_ctrl_tb.sv
// mpc_partition_ctrl_tb: apb bench with a register model of the block.
// assumes design and checker are compiled first.
`timescale 1ns/1ns
`include "mpc_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module mpc_partition_ctrl_tb;
	import mpc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic warm_reset, loader_mode, hw_lock_clear, watchdog_timeout, external_data_move;
	logic chip_select_one_n, chip_select_two_n, move_in_data, move_out_of_range;
	logic check_rd_en, program_load_mode, app_start;
	logic [7:0] check_rd_data;
	mpc_addr_t move_addr, partition_addr, range_top, check_rd_addr, pa;
	mpc_crc_t check_stored_crc, crc;
	int errors = 0;
	int compares = 0;
	int seed, n, ta;
	logic [3:0] bound, span;
	logic rng, sel2, unlock, lock, en, ldr;
	mpc_partition_ctrl dut (.*);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// check memory answers in the cycle its address stands, as the sequencer consumes it
	assign check_rd_data = check_rd_addr[7:0] ^ check_rd_addr[15:8] ^ 8'h5a;
	function automatic logic [7:0] ctrl();
		return {bound, rng, sel2, unlock, lock};
	endfunction : ctrl
	function automatic mpc_addr_t dec(input logic [3:0] c);
		return (c == 4'hf) ? 16'h8000 : {1'b0, c, 11'h000};
	endfunction : dec
	task automatic clr();
		bound = 4'hf;
		rng = 1'b1;
		lock = 1'b0;
	endtask : clr
	task automatic upd(input logic [11:0] a, input logic [7:0] d);
		logic u;
		u = unlock;
		if (a == `MPC_ADDR_PART_CTRL) begin
			if (ta == 2) unlock = d[1];
			sel2 = d[2];
			if (ldr) rng = d[3];
			if (u) bound = (d[7:4] == 4'h0 && lock) ? 4'hf : d[7:4];
		end
		if (ldr && a == `MPC_ADDR_CHECK_CFG) {span, en} = {d[7:4], d[0]};
		if (ldr && a == `MPC_ADDR_LOADER_CMD && d[1]) clr();
		else if (ldr && a == `MPC_ADDR_LOADER_CMD && d[0]) lock = 1'b1;
		ta = (a != `MPC_ADDR_TIMED_ACC) ? 0 : (d == 8'haa) ? 1 : (ta == 1 && d == 8'h55) ? 2 : 0;
	endtask : upd
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0000_00, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 64);
		if (k >= 64) errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w) upd(a, d);
	endtask : apb
	task automatic rdc();
		apb(0, `MPC_ADDR_PART_CTRL, 8'h00);
		`CHK(rd[7:0], ctrl())
	endtask : rdc
	task automatic unl();
		apb(1, `MPC_ADDR_TIMED_ACC, 8'haa);
		apb(1, `MPC_ADDR_TIMED_ACC, 8'h55);
		apb(1, `MPC_ADDR_PART_CTRL, {bound, rng, sel2, 2'b10});
	endtask : unl
	task automatic moves();
		logic m;
		apb(1, `MPC_ADDR_PART_CTRL, {bound, rng, 1'($urandom), 2'b00});
		repeat (24) begin
			@(posedge pclk);
			m = 1'($urandom);
			pa = mpc_addr_t'($urandom);
			external_data_move <= m;
			move_addr <= pa;
			@(posedge pclk);
			#1;
			`CHK({chip_select_one_n, chip_select_two_n}, {!(m && !sel2), !(m && sel2)})
			`CHK({partition_addr, range_top}, {dec(bound), rng ? 16'h7fff : 16'h1fff})
			if (m) `CHK({move_in_data, move_out_of_range}, {pa >= dec(bound), pa > (rng ? 16'h7fff : 16'h1fff)})
		end
		@(posedge pclk);
		external_data_move <= 1'b0;
	endtask : moves
	task automatic chk_run(input logic pass);
		crc = 16'hffff;
		for (int i = 0; i < span * 4096; i++) begin
			crc ^= {i[7:0] ^ i[15:8] ^ 8'h5a, 8'h00};
			repeat (8) crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h1021 : {crc[14:0], 1'b0};
		end
		check_stored_crc <= pass ? crc : ~crc;
		watchdog_timeout <= 1'b1;
		repeat (4) @(posedge pclk);
		watchdog_timeout <= 1'b0;
		n = 0;
		do begin
			apb(0, `MPC_ADDR_STATUS, 8'h00);
			n++;
		end while ((rd[0] !== 1'b0 || n < 2) && n < 6000);
		if (n >= 6000) errors++;
		`CHK({rd[2:1], program_load_mode, app_start}, pass ? 4'b1001 : 4'b0110)
	endtask : chk_run
	task automatic end_sim();
		if (errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		#300000;
		errors++;
		end_sim();
	end
	initial begin
		seed = $urandom(54508);
		{presetn, psel, penable, pwrite, warm_reset, loader_mode} = '0;
		{hw_lock_clear, watchdog_timeout, external_data_move, paddr, pwdata} = '0;
		{move_addr, check_stored_crc} = '0;
		{bound, rng, sel2, unlock, lock, span, en, ldr, ta} = {4'hf, 1'b1, 9'h000, 32'h0};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rdc();
		`CHK({partition_addr, range_top, app_start}, {16'h8000, 16'h7fff, 1'b1})
		apb(1, `MPC_ADDR_PART_CTRL, 8'h3e);
		apb(1, `MPC_ADDR_LOADER_CMD, 8'h01);
		apb(1, `MPC_ADDR_CHECK_CFG, 8'h11);
		rdc();
		apb(0, `MPC_ADDR_CHECK_CFG, 8'h00);
		`CHK(rd[7:0], 8'h00)
		moves();
		unl();
		for (int c = 0; c < 16; c++) begin
			apb(1, `MPC_ADDR_PART_CTRL, {c[3:0], rng, sel2, 2'b00});
			rdc();
			`CHK(partition_addr, dec(c[3:0]))
		end
		apb(1, `MPC_ADDR_PART_CTRL, {4'h5, rng, sel2, 2'b00});
		warm_reset <= 1'b1;
		repeat (4) @(posedge pclk);
		warm_reset <= 1'b0;
		repeat (4) @(posedge pclk);
		unlock = 1'b0;
		rdc();
		ldr = 1'b1;
		loader_mode <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1, `MPC_ADDR_PART_CTRL, {bound, 1'b0, sel2, 2'b00});
		apb(1, `MPC_ADDR_LOADER_CMD, 8'h01);
		apb(1, `MPC_ADDR_CHECK_CFG, 8'h11);
		rdc();
		moves();
		unl();
		apb(1, `MPC_ADDR_PART_CTRL, {4'h0, rng, sel2, 2'b00});
		rdc();
		apb(1, `MPC_ADDR_PART_CTRL, {4'h3, rng, sel2, 2'b00});
		hw_lock_clear <= 1'b1;
		repeat (4) @(posedge pclk);
		hw_lock_clear <= 1'b0;
		repeat (4) @(posedge pclk);
		clr();
		rdc();
		apb(1, 12'h3fc, 8'hff);
		`CHK(err, 1'b1)
		rdc();
		apb(1, `MPC_ADDR_LOADER_CMD, 8'h01);
		apb(1, `MPC_ADDR_LOADER_CMD, 8'h02);
		rdc();
		apb(0, `MPC_ADDR_CHECK_CFG, 8'h00);
		`CHK(rd[7:0], 8'h11)
		chk_run(1'b0);
		chk_run(1'b1);
		end_sim();
	end
endmodule : mpc_partition_ctrl_tb

// file: core/mpc_crc16.sv
// mpc_crc16: byte-wise crc accumulator for the power-up integrity check.
// assumes bytes arrive one per valid pulse on the same clock.
`timescale 1ns/1ns
`include "mpc_params.svh"

module mpc_crc16 (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// byte stream
	input wire logic clear,
	input wire logic valid,
	input wire logic [7:0] data,
	// result
	output mpc_pkg::mpc_crc_t crc_q
);
	import mpc_pkg::*;

	function automatic mpc_crc_t crc_byte(input mpc_crc_t c, input logic [7:0] b);
		mpc_crc_t r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ `MPC_CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : crc_byte

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crc_q <= `MPC_CRC_INIT;
		end else if (clear) begin
			crc_q <= `MPC_CRC_INIT;
		end else if (valid) begin
			crc_q <= crc_byte(crc_q, data);
		end
	end
endmodule : mpc_crc16

// file: core/mpc_partition_ctrl.sv
// mpc_partition_ctrl: memory partition and integrity check registers on apb,
// with chip select steering and the power-up crc check.
// assumes presetn is the battery-loss reset; other resets come on warm_reset.
// Functional notes
// - partition_bound gives first data address; program space lies below it.
// - partition_bound writes only take effect while partition_write_unlock is 1.
// - with unlock set, plain writes reach partition_bound without timed access.
// - partition_bound goes to 1111b on battery loss or lock clear only.
// - writing 0000b while locked loads 1111b instead.
// - codes 0..13 step 0800h; 1110b is 7000h, 1111b is 8000h.
// - range_select 0 limits top to 1FFFH, 1 to 7FFFH.
// - range_select goes to 1 on battery loss or lock clear only.
// - external moves drive chip select one, or two when second_select_enable.
// - partition_write_unlock changes only by timed access; resets to 0.
// - lock_flag changes only by loader lock and unlock commands or the hw_lock_clear pin.
// - check_span sets the checked range in 4K blocks.
// - with check enabled and check_span nonzero, crc runs after power-up or watchdog timeout.
// - a failed crc comparison enters program load mode.
// - check fields clear on battery loss, kept otherwise, loader-only writes.
`timescale 1ns/1ns
`include "mpc_params.svh"

module mpc_partition_ctrl (
	// clock and battery-loss reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from outside the clock domain
	input wire logic warm_reset,
	input wire logic loader_mode,
	input wire logic hw_lock_clear,
	input wire logic watchdog_timeout,
	// external data move request from the core
	input wire logic external_data_move,
	input wire mpc_pkg::mpc_addr_t move_addr,
	output logic chip_select_one_n,
	output logic chip_select_two_n,
	output logic move_in_data,
	output logic move_out_of_range,
	output mpc_pkg::mpc_addr_t partition_addr,
	output mpc_pkg::mpc_addr_t range_top,
	// integrity check memory port and result
	output mpc_pkg::mpc_addr_t check_rd_addr,
	output logic check_rd_en,
	input wire logic [7:0] check_rd_data,
	input wire mpc_pkg::mpc_crc_t check_stored_crc,
	output logic program_load_mode,
	output logic app_start
);
	import mpc_pkg::*;

	// pin synchronisers
	logic [3:0] pin_meta_q;
	logic [3:0] pin_sync_q;
	logic wdt_prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= 4'h0;
			pin_sync_q <= 4'h0;
			wdt_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= {watchdog_timeout, hw_lock_clear, loader_mode, warm_reset};
			pin_sync_q <= pin_meta_q;
			wdt_prev_q <= pin_sync_q[3];
		end
	end
	logic warm_s;
	logic loader_s;
	logic hw_clr_s;
	logic wdt_rise;
	assign warm_s = pin_sync_q[0];
	assign loader_s = pin_sync_q[1];
	assign hw_clr_s = pin_sync_q[2];
	assign wdt_rise = pin_sync_q[3] & ~wdt_prev_q;

	// apb timing: one wait state, effects at the completing edge
	logic acc_go;
	logic acc_done;
	logic wr_done;
	assign acc_go = psel & penable & ~pready;
	assign acc_done = psel & penable & pready;
	assign wr_done = acc_done & pwrite;

	logic hit_cfg;
	logic hit_ctrl;
	logic hit_ta;
	logic hit_cmd;
	logic hit_stat;
	assign hit_cfg = (paddr == `MPC_ADDR_CHECK_CFG);
	assign hit_ctrl = (paddr == `MPC_ADDR_PART_CTRL);
	assign hit_ta = (paddr == `MPC_ADDR_TIMED_ACC);
	assign hit_cmd = (paddr == `MPC_ADDR_LOADER_CMD);
	assign hit_stat = (paddr == `MPC_ADDR_STATUS);

	// register state
	logic [3:0] partition_bound_q;
	logic range_select_q;
	logic second_select_enable_q;
	logic partition_write_unlock_q;
	logic lock_flag_q;
	logic [3:0] check_span_q;
	logic check_enable_q;
	mpc_ta_state_t ta_q;

	logic lock_clear;
	assign lock_clear = hw_clr_s | (wr_done & hit_cmd & loader_s & pwdata[`MPC_CMD_UNLOCK_BIT]);

	// timed access: key1 then key2 opens the next write to the control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ta_q <= MPC_TA_NONE;
		end else if (warm_s) begin
			ta_q <= MPC_TA_NONE;
		end else if (wr_done) begin
			unique case (ta_q)
				MPC_TA_NONE: begin
					ta_q <= (hit_ta && pwdata[7:0] == `MPC_TA_KEY1) ? MPC_TA_HALF : MPC_TA_NONE;
				end
				MPC_TA_HALF: begin
					ta_q <= (hit_ta && pwdata[7:0] == `MPC_TA_KEY2) ? MPC_TA_OPEN : MPC_TA_NONE;
				end
				MPC_TA_OPEN: begin
					ta_q <= MPC_TA_NONE;
				end
				default: begin
					ta_q <= MPC_TA_NONE;
				end
			endcase
		end
	end

	// unlock bit: timed access only, cleared by every reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			partition_write_unlock_q <= 1'b0;
		end else if (warm_s) begin
			partition_write_unlock_q <= 1'b0;
		end else if (wr_done && hit_ctrl && ta_q == MPC_TA_OPEN) begin
			partition_write_unlock_q <= pwdata[`MPC_UNLOCK_BIT];
		end
	end

	// partition bound
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			partition_bound_q <= `MPC_PB_RST;
		end else if (lock_clear) begin
			partition_bound_q <= `MPC_PB_RST;
		end else if (wr_done && hit_ctrl && partition_write_unlock_q) begin
			if (pwdata[7:4] == `MPC_PB_ZERO && lock_flag_q) begin
				partition_bound_q <= `MPC_PB_RST;
			end else begin
				partition_bound_q <= pwdata[7:4];
			end
		end
	end

	// range select: loader only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_select_q <= `MPC_RANGE_RST;
		end else if (lock_clear) begin
			range_select_q <= `MPC_RANGE_RST;
		end else if (wr_done && hit_ctrl && loader_s) begin
			range_select_q <= pwdata[`MPC_RANGE_BIT];
		end
	end

	// second chip select enable: unrestricted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_select_enable_q <= 1'b0;
		end else if (wr_done && hit_ctrl) begin
			second_select_enable_q <= pwdata[`MPC_SEL2_BIT];
		end
	end

	// security lock: set by loader command, cleared by loader command or hw_lock_clear pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_flag_q <= 1'b0;
		end else if (lock_clear) begin
			lock_flag_q <= 1'b0;
		end else if (wr_done && hit_cmd && loader_s && pwdata[`MPC_CMD_LOCK_BIT]) begin
			lock_flag_q <= 1'b1;
		end
	end

	// integrity check config: loader only, cleared on battery loss only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			check_span_q <= `MPC_SPAN_RST;
			check_enable_q <= 1'b0;
		end else if (wr_done && hit_cfg && loader_s) begin
			check_span_q <= pwdata[7:4];
			check_enable_q <= pwdata[`MPC_CHKEN_BIT];
		end
	end

	// integrity check sequencer
	mpc_chk_state_t chk_q;
	logic run_pending_q;
	mpc_addr_t chk_addr_q;
	logic chk_last_q;
	logic chk_fail_q;
	logic chk_pass_q;
	logic crc_clear;
	logic crc_valid;
	mpc_crc_t crc_val;
	logic [16:0] chk_end;
	assign chk_end = {1'b0, check_span_q, 12'h000};
	assign crc_clear = (chk_q == MPC_CHK_IDLE);
	assign crc_valid = (chk_q == MPC_CHK_DATA);

	mpc_crc16 u_crc (
		.pclk(pclk),
		.presetn(presetn),
		.clear(crc_clear),
		.valid(crc_valid),
		.data(check_rd_data),
		.crc_q(crc_val)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_pending_q <= 1'b1;
		end else if (wdt_rise) begin
			run_pending_q <= 1'b1;
		end else if (chk_q == MPC_CHK_IDLE) begin
			run_pending_q <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_q <= MPC_CHK_IDLE;
			chk_addr_q <= 16'h0000;
			chk_last_q <= 1'b0;
			chk_fail_q <= 1'b0;
			chk_pass_q <= 1'b0;
		end else begin
			unique case (chk_q)
				MPC_CHK_IDLE: begin
					if (run_pending_q) begin
						chk_addr_q <= 16'h0000;
						chk_fail_q <= 1'b0;
						chk_pass_q <= 1'b0;
						if (check_enable_q && check_span_q != `MPC_SPAN_RST) begin
							chk_q <= MPC_CHK_ADDR;
						end else begin
							chk_pass_q <= 1'b1;
						end
					end
				end
				MPC_CHK_ADDR: begin
					chk_last_q <= ({1'b0, chk_addr_q} == chk_end - 17'd1);
					chk_q <= MPC_CHK_DATA;
				end
				MPC_CHK_DATA: begin
					chk_addr_q <= chk_addr_q + 16'h0001;
					chk_q <= chk_last_q ? MPC_CHK_CMP : MPC_CHK_ADDR;
				end
				MPC_CHK_CMP: begin
					chk_fail_q <= (crc_val != check_stored_crc);
					chk_pass_q <= (crc_val == check_stored_crc);
					chk_q <= MPC_CHK_IDLE;
				end
				default: begin
					chk_q <= MPC_CHK_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			check_rd_addr <= 16'h0000;
			check_rd_en <= 1'b0;
			program_load_mode <= 1'b0;
			app_start <= 1'b0;
		end else begin
			check_rd_addr <= chk_addr_q;
			check_rd_en <= (chk_q == MPC_CHK_ADDR);
			program_load_mode <= chk_fail_q;
			app_start <= chk_pass_q & ~run_pending_q & (chk_q == MPC_CHK_IDLE);
		end
	end

	// partition and range decode
	mpc_addr_t part_addr_d;
	mpc_addr_t top_d;
	always_comb begin
		if (partition_bound_q == `MPC_PB_RST) begin
			part_addr_d = `MPC_PB_ADDR_F;
		end else if (partition_bound_q == `MPC_PB_LAST_STEP) begin
			part_addr_d = `MPC_PB_ADDR_E;
		end else begin
			part_addr_d = 16'({12'h000, partition_bound_q} * `MPC_PB_STEP);
		end
		top_d = range_select_q ? `MPC_TOP_LARGE : `MPC_TOP_SMALL;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			partition_addr <= `MPC_PB_ADDR_F;
			range_top <= `MPC_TOP_LARGE;
			chip_select_one_n <= 1'b1;
			chip_select_two_n <= 1'b1;
			move_in_data <= 1'b0;
			move_out_of_range <= 1'b0;
		end else begin
			partition_addr <= part_addr_d;
			range_top <= top_d;
			chip_select_one_n <= ~(external_data_move & ~second_select_enable_q);
			chip_select_two_n <= ~(external_data_move & second_select_enable_q);
			move_in_data <= external_data_move && move_addr >= part_addr_d;
			move_out_of_range <= external_data_move && move_addr > top_d;
		end
	end

	// apb answer
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit_cfg) begin
			rd_byte = {check_span_q, 3'b000, check_enable_q};
		end else if (hit_ctrl) begin
			rd_byte = {partition_bound_q, range_select_q, second_select_enable_q,
				partition_write_unlock_q, lock_flag_q};
		end else if (hit_stat) begin
			rd_byte = {4'h0, loader_s, chk_pass_q, chk_fail_q, ~crc_clear};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc_go;
			pslverr <= acc_go & ~(hit_cfg | hit_ctrl | hit_ta | hit_cmd | hit_stat);
			if (acc_go && !pwrite) begin
				prdata <= {24'h00_0000, rd_byte};
			end
		end
	end
endmodule : mpc_partition_ctrl

// file: shared/mpc_params.svh
// mpc_params.svh: offsets, field positions, reset values and codes of the
// memory partition control block; definitions only, included by bare name.
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH

// register indices and byte addresses (byte address = 4 * index)
`define MPC_IDX_CHECK_CFG 8'hc1
`define MPC_IDX_PART_CTRL 8'hc6
`define MPC_IDX_TIMED_ACC 8'hc7
`define MPC_IDX_LOADER_CMD 8'hc8
`define MPC_IDX_STATUS 8'hc9
`define MPC_ADDR_CHECK_CFG 12'h0304
`define MPC_ADDR_PART_CTRL 12'h0318
`define MPC_ADDR_TIMED_ACC 12'h031c
`define MPC_ADDR_LOADER_CMD 12'h0320
`define MPC_ADDR_STATUS 12'h0324

// memory_partition_control fields
`define MPC_PB_LSB 4
`define MPC_RANGE_BIT 3
`define MPC_SEL2_BIT 2
`define MPC_UNLOCK_BIT 1
`define MPC_LOCK_BIT 0
// integrity_check_config fields
`define MPC_SPAN_LSB 4
`define MPC_CHKEN_BIT 0
// loader command bits
`define MPC_CMD_LOCK_BIT 0
`define MPC_CMD_UNLOCK_BIT 1

// reset values and special bound codes
`define MPC_PB_RST 4'h0f
`define MPC_PB_ZERO 4'h00
`define MPC_PB_LAST_STEP 4'h0e
`define MPC_RANGE_RST 1'b1
`define MPC_SPAN_RST 4'h00

// partition steps and range tops
`define MPC_PB_STEP 16'h0800
`define MPC_PB_ADDR_E 16'h7000
`define MPC_PB_ADDR_F 16'h8000
`define MPC_TOP_SMALL 16'h1fff
`define MPC_TOP_LARGE 16'h7fff

// timed access key bytes
`define MPC_TA_KEY1 8'haa
`define MPC_TA_KEY2 8'h55

// integrity check
`define MPC_BLOCK_SHIFT 12
`define MPC_CRC_POLY 16'h1021
`define MPC_CRC_INIT 16'hffff

`endif

// file: shared/mpc_pkg.sv
// mpc_pkg: types of the memory partition control block.
// assumes mpc_params.svh is on the include path.
package mpc_pkg;
	typedef enum logic [3:0] {
		MPC_CHK_IDLE = 4'b0001,
		MPC_CHK_ADDR = 4'b0010,
		MPC_CHK_DATA = 4'b0100,
		MPC_CHK_CMP = 4'b1000
	} mpc_chk_state_t;

	typedef enum logic [2:0] {
		MPC_TA_NONE = 3'b001,
		MPC_TA_HALF = 3'b010,
		MPC_TA_OPEN = 3'b100
	} mpc_ta_state_t;

	typedef logic [15:0] mpc_addr_t;
	typedef logic [15:0] mpc_crc_t;
endpackage : mpc_pkg
